// file: hw/homing_scale_pkg.sv
// Purpose: constants for the homing and unit-scaling block
// Assumes: object dictionary entries reached by index and subindex
// Notes: reset values are the preset values of each entry
package homing_scale_pkg;
  // ----------------------------------------
  // object indices
  // ----------------------------------------
  localparam logic [15:0] IDX_GEAR_RATIO = 16'h6091;
  localparam logic [15:0] IDX_FEED = 16'h6092;
  localparam logic [15:0] IDX_SPEED_FACTOR = 16'h6096;
  localparam logic [15:0] IDX_ACCEL_FACTOR = 16'h6097;
  localparam logic [15:0] IDX_HOMING_METHOD = 16'h6098;
  localparam logic [15:0] IDX_HOMING_SPEEDS = 16'h6099;
  localparam logic [15:0] IDX_HOMING_RAMP = 16'h609a;
  localparam logic [15:0] IDX_JERK_FACTOR = 16'h60a2;
  localparam logic [15:0] IDX_PROFILE_JERK = 16'h60a4;
  localparam logic [15:0] IDX_RAMP_TYPE = 16'h6086;
  // ----------------------------------------
  // subindices and reset values
  // ----------------------------------------
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_FIRST = 8'h01;
  localparam logic [7:0] SUB_SECOND = 8'h02;
  localparam logic [7:0] SUB_JERK_LAST = 8'h04;
  localparam logic [7:0] PAIR_ENTRIES = 8'h02;
  localparam logic [7:0] JERK_ENTRIES = 8'h04;
  localparam logic [31:0] ONE_RESET = 32'h0000_0001;
  localparam logic [31:0] SWITCH_SPEED_RESET = 32'h0000_0032;
  localparam logic [31:0] ZERO_SPEED_RESET = 32'h0000_000a;
  localparam logic [31:0] HOMING_RAMP_RESET = 32'h0000_01f4;
  localparam logic [7:0] HOMING_METHOD_RESET = 8'h23;
  localparam logic [31:0] JERK_RESET = 32'h0000_03e8;
  localparam logic [15:0] RAMP_TRAPEZOID = 16'h0000;
  localparam logic [15:0] RAMP_JERK_LIMITED = 16'h0003;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int INDEX_MIN_WIDTH_PS = 31250000;
  // longest filter that still keeps every legal pulse: round down
  localparam int INDEX_FILTER_CYCLES = INDEX_MIN_WIDTH_PS / CLK_PERIOD_PS;
  // ----------------------------------------
  // homing states
  // ----------------------------------------
  typedef enum logic [4:0] {
    HOME_IDLE = 5'b00001,
    HOME_RAMP = 5'b00010,
    HOME_SWITCH = 5'b00100,
    HOME_ZERO = 5'b01000,
    HOME_DONE = 5'b10000
  } home_state_t;
endpackage

// file: hw/homing_scale.sv
// Purpose: unit scaling factors and homing speed sequencer
// Assumes: object dictionary writes arrive as index/subindex strobes on mclk
// Notes: division by a scaling denominator is left to the consumer; only ratios
//   are held here, and zero denominators are never stored
//
// How it works
// - gear ratio is motor revolutions over shaft revolutions, both stored.
// - feed constant is feed over shaft revolutions, both defaulting to one.
// - speed factor pair scales user speed into internal units.
// - acceleration factor pair scales user acceleration into internal units.
// - jerk factor pair scales user jerk into internal units.
// - entry one is numerator, entry two denominator, both reset to one.
// - switch search runs at first homing speed, default 32 hex.
// - reference search runs at second, lower homing speed, default 0a hex.
// - homing ramp starts from second homing speed.
// - index pulses at least the minimum width are caught.
// - ramp only used while starting the homing motion.
// - switch reached: drop to reference speed at once.
// - end position reached: stop at once.
// - jerk limit used only with jerk-limited ramp type.
// - all four jerk values zero means no jerk limit.
// - ramp type 0 is trapezoid, 3 is jerk-limited.
// - four jerk entries, each defaulting to 3e8 hex.
`timescale 1ns/1ps
module homing_scale #(
  parameter int INDEX_FILTER = homing_scale_pkg::INDEX_FILTER_CYCLES
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic od_wr,
  input wire logic od_rd,
  input wire logic [15:0] od_index,
  input wire logic [7:0] od_sub,
  input wire logic [31:0] od_wdata,
  output logic [31:0] od_rdata,
  output logic od_ack,
  output logic od_err,
  input wire logic home_start,
  input wire logic ref_switch,
  input wire logic index_pulse,
  input wire logic speed_tick,
  output logic [31:0] speed_cmd,
  output logic homing_busy,
  output logic homing_done,
  output logic [31:0] speed_num,
  output logic [31:0] speed_den,
  output logic [31:0] accel_num,
  output logic [31:0] accel_den,
  output logic [31:0] jerk_num,
  output logic [31:0] jerk_den,
  output logic [31:0] gear_num,
  output logic [31:0] gear_den,
  output logic [31:0] feed_num,
  output logic [31:0] feed_den,
  output logic jerk_limit_en,
  output logic [31:0] jerk_accel_begin,
  output logic [31:0] jerk_accel_end,
  output logic [31:0] jerk_brake_begin,
  output logic [31:0] jerk_brake_end,
  output logic [7:0] homing_method
);
  // ----------------------------------------
  // object storage
  // ----------------------------------------
  logic [31:0] gear_motor_reg, gear_shaft_reg;
  logic [31:0] feed_value_reg, feed_shaft_reg;
  logic [31:0] speed_num_reg, speed_den_reg;
  logic [31:0] accel_num_reg, accel_den_reg;
  logic [31:0] jerk_num_reg, jerk_den_reg;
  logic [31:0] switch_speed_reg, zero_speed_reg, ramp_accel_reg;
  logic [7:0] method_reg;
  logic [15:0] ramp_type_reg;
  logic [31:0] jerk_reg [4];

  // write strobe for one index and subindex
  function automatic logic hit(input logic [15:0] idx, input logic [7:0] sub,
                               input logic [15:0] want_idx, input logic [7:0] want_sub);
    hit = (idx == want_idx) && (sub == want_sub);
  endfunction

  function automatic logic den_ok(input logic [31:0] v);
    den_ok = (v != 32'h0000_0000);
  endfunction

  // gear ratio entries, motor over shaft
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gear_motor_reg <= homing_scale_pkg::ONE_RESET;
      gear_shaft_reg <= homing_scale_pkg::ONE_RESET;
    end else if (od_wr) begin
      if (hit(od_index, od_sub, homing_scale_pkg::IDX_GEAR_RATIO, homing_scale_pkg::SUB_FIRST)) begin
        gear_motor_reg <= od_wdata;
      end
      if (hit(od_index, od_sub, homing_scale_pkg::IDX_GEAR_RATIO, homing_scale_pkg::SUB_SECOND)
          && den_ok(od_wdata)) begin
        gear_shaft_reg <= od_wdata;
      end
    end
  end

  // feed entries, feed over shaft revolutions
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      feed_value_reg <= homing_scale_pkg::ONE_RESET;
      feed_shaft_reg <= homing_scale_pkg::ONE_RESET;
    end else if (od_wr) begin
      if (hit(od_index, od_sub, homing_scale_pkg::IDX_FEED, homing_scale_pkg::SUB_FIRST)) begin
        feed_value_reg <= od_wdata;
      end
      if (hit(od_index, od_sub, homing_scale_pkg::IDX_FEED, homing_scale_pkg::SUB_SECOND)
          && den_ok(od_wdata)) begin
        feed_shaft_reg <= od_wdata;
      end
    end
  end

  // conversion factor pairs, numerator then denominator
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      speed_num_reg <= homing_scale_pkg::ONE_RESET;
      speed_den_reg <= homing_scale_pkg::ONE_RESET;
      accel_num_reg <= homing_scale_pkg::ONE_RESET;
      accel_den_reg <= homing_scale_pkg::ONE_RESET;
      jerk_num_reg <= homing_scale_pkg::ONE_RESET;
      jerk_den_reg <= homing_scale_pkg::ONE_RESET;
    end else if (od_wr) begin
      if (hit(od_index, od_sub, homing_scale_pkg::IDX_SPEED_FACTOR, homing_scale_pkg::SUB_FIRST)) begin
        speed_num_reg <= od_wdata;
      end
      if (hit(od_index, od_sub, homing_scale_pkg::IDX_SPEED_FACTOR, homing_scale_pkg::SUB_SECOND)
          && den_ok(od_wdata)) begin
        speed_den_reg <= od_wdata;
      end
      if (hit(od_index, od_sub, homing_scale_pkg::IDX_ACCEL_FACTOR, homing_scale_pkg::SUB_FIRST)) begin
        accel_num_reg <= od_wdata;
      end
      if (hit(od_index, od_sub, homing_scale_pkg::IDX_ACCEL_FACTOR, homing_scale_pkg::SUB_SECOND)
          && den_ok(od_wdata)) begin
        accel_den_reg <= od_wdata;
      end
      if (hit(od_index, od_sub, homing_scale_pkg::IDX_JERK_FACTOR, homing_scale_pkg::SUB_FIRST)) begin
        jerk_num_reg <= od_wdata;
      end
      if (hit(od_index, od_sub, homing_scale_pkg::IDX_JERK_FACTOR, homing_scale_pkg::SUB_SECOND)
          && den_ok(od_wdata)) begin
        jerk_den_reg <= od_wdata;
      end
    end
  end

  // homing speeds, ramp, method and ramp type
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      switch_speed_reg <= homing_scale_pkg::SWITCH_SPEED_RESET;
      zero_speed_reg <= homing_scale_pkg::ZERO_SPEED_RESET;
      ramp_accel_reg <= homing_scale_pkg::HOMING_RAMP_RESET;
      method_reg <= homing_scale_pkg::HOMING_METHOD_RESET;
      ramp_type_reg <= homing_scale_pkg::RAMP_TRAPEZOID;
    end else if (od_wr) begin
      if (hit(od_index, od_sub, homing_scale_pkg::IDX_HOMING_SPEEDS, homing_scale_pkg::SUB_FIRST)) begin
        switch_speed_reg <= od_wdata;
      end
      if (hit(od_index, od_sub, homing_scale_pkg::IDX_HOMING_SPEEDS, homing_scale_pkg::SUB_SECOND)) begin
        zero_speed_reg <= od_wdata;
      end
      if (hit(od_index, od_sub, homing_scale_pkg::IDX_HOMING_RAMP, homing_scale_pkg::SUB_COUNT)) begin
        ramp_accel_reg <= od_wdata;
      end
      if (hit(od_index, od_sub, homing_scale_pkg::IDX_HOMING_METHOD, homing_scale_pkg::SUB_COUNT)) begin
        method_reg <= od_wdata[7:0];
      end
      if (hit(od_index, od_sub, homing_scale_pkg::IDX_RAMP_TYPE, homing_scale_pkg::SUB_COUNT)) begin
        ramp_type_reg <= od_wdata[15:0];
      end
    end
  end

  // four jerk entries at subindex 1 to 4
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) begin
        jerk_reg[i] <= homing_scale_pkg::JERK_RESET;
      end
    end else if (od_wr && od_index == homing_scale_pkg::IDX_PROFILE_JERK
                 && od_sub >= homing_scale_pkg::SUB_FIRST && od_sub <= homing_scale_pkg::SUB_JERK_LAST) begin
      jerk_reg[2'(od_sub - homing_scale_pkg::SUB_FIRST)] <= od_wdata;
    end
  end

  // ----------------------------------------
  // read and acknowledge
  // ----------------------------------------
  logic [31:0] rd_value;
  logic rd_known;

  // read mux; subindex 0 returns entry count, or the value of single entries 6098, 609a, 6086
  always_comb begin
    rd_value = 32'h0000_0000;
    rd_known = 1'b1;
    case ({od_index, od_sub})
      {homing_scale_pkg::IDX_GEAR_RATIO, homing_scale_pkg::SUB_COUNT},
      {homing_scale_pkg::IDX_FEED, homing_scale_pkg::SUB_COUNT},
      {homing_scale_pkg::IDX_SPEED_FACTOR, homing_scale_pkg::SUB_COUNT},
      {homing_scale_pkg::IDX_ACCEL_FACTOR, homing_scale_pkg::SUB_COUNT},
      {homing_scale_pkg::IDX_JERK_FACTOR, homing_scale_pkg::SUB_COUNT},
      {homing_scale_pkg::IDX_HOMING_SPEEDS, homing_scale_pkg::SUB_COUNT}: begin
        rd_value = {24'h00_0000, homing_scale_pkg::PAIR_ENTRIES};
      end
      {homing_scale_pkg::IDX_PROFILE_JERK, homing_scale_pkg::SUB_COUNT}: begin
        rd_value = {24'h00_0000, homing_scale_pkg::JERK_ENTRIES};
      end
      {homing_scale_pkg::IDX_GEAR_RATIO, homing_scale_pkg::SUB_FIRST}: rd_value = gear_motor_reg;
      {homing_scale_pkg::IDX_GEAR_RATIO, homing_scale_pkg::SUB_SECOND}: rd_value = gear_shaft_reg;
      {homing_scale_pkg::IDX_FEED, homing_scale_pkg::SUB_FIRST}: rd_value = feed_value_reg;
      {homing_scale_pkg::IDX_FEED, homing_scale_pkg::SUB_SECOND}: rd_value = feed_shaft_reg;
      {homing_scale_pkg::IDX_SPEED_FACTOR, homing_scale_pkg::SUB_FIRST}: rd_value = speed_num_reg;
      {homing_scale_pkg::IDX_SPEED_FACTOR, homing_scale_pkg::SUB_SECOND}: rd_value = speed_den_reg;
      {homing_scale_pkg::IDX_ACCEL_FACTOR, homing_scale_pkg::SUB_FIRST}: rd_value = accel_num_reg;
      {homing_scale_pkg::IDX_ACCEL_FACTOR, homing_scale_pkg::SUB_SECOND}: rd_value = accel_den_reg;
      {homing_scale_pkg::IDX_JERK_FACTOR, homing_scale_pkg::SUB_FIRST}: rd_value = jerk_num_reg;
      {homing_scale_pkg::IDX_JERK_FACTOR, homing_scale_pkg::SUB_SECOND}: rd_value = jerk_den_reg;
      {homing_scale_pkg::IDX_HOMING_SPEEDS, homing_scale_pkg::SUB_FIRST}: rd_value = switch_speed_reg;
      {homing_scale_pkg::IDX_HOMING_SPEEDS, homing_scale_pkg::SUB_SECOND}: rd_value = zero_speed_reg;
      {homing_scale_pkg::IDX_HOMING_RAMP, homing_scale_pkg::SUB_COUNT}: rd_value = ramp_accel_reg;
      {homing_scale_pkg::IDX_HOMING_METHOD, homing_scale_pkg::SUB_COUNT}: rd_value = {24'h00_0000, method_reg};
      {homing_scale_pkg::IDX_RAMP_TYPE, homing_scale_pkg::SUB_COUNT}: rd_value = {16'h0000, ramp_type_reg};
      default: begin
        if (od_index == homing_scale_pkg::IDX_PROFILE_JERK && od_sub >= homing_scale_pkg::SUB_FIRST
            && od_sub <= homing_scale_pkg::SUB_JERK_LAST) begin
          rd_value = jerk_reg[2'(od_sub - homing_scale_pkg::SUB_FIRST)];
        end else begin
          rd_known = 1'b0;
        end
      end
    endcase
  end

  // one-cycle answer; err flags unknown entry, read-only count, zero denominator
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      od_rdata <= 32'h0000_0000;
      od_ack <= 1'b0;
      od_err <= 1'b0;
    end else begin
      od_ack <= od_wr | od_rd;
      od_rdata <= od_rd ? rd_value : 32'h0000_0000;
      od_err <= (od_rd & ~rd_known)
        | (od_wr & (~rd_known | (od_sub == homing_scale_pkg::SUB_COUNT && od_index != homing_scale_pkg::IDX_HOMING_RAMP
           && od_index != homing_scale_pkg::IDX_HOMING_METHOD && od_index != homing_scale_pkg::IDX_RAMP_TYPE)
           // zero denominator refused; a zero jerk entry stays legal
           | (od_sub == homing_scale_pkg::SUB_SECOND && od_wdata == 32'h0000_0000
              && od_index != homing_scale_pkg::IDX_HOMING_SPEEDS && od_index != homing_scale_pkg::IDX_PROFILE_JERK)));
    end
  end

  // ----------------------------------------
  // pin synchronisers and index filter
  // ----------------------------------------
  logic [1:0] sw_sync_reg, idx_sync_reg;
  logic sw_prev_reg;
  logic [23:0] idx_cnt_reg;
  logic idx_seen_reg;

  // two flops per pin
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sw_sync_reg <= 2'b00;
      idx_sync_reg <= 2'b00;
      sw_prev_reg <= 1'b0;
    end else begin
      sw_sync_reg <= {sw_sync_reg[0], ref_switch};
      idx_sync_reg <= {idx_sync_reg[0], index_pulse};
      sw_prev_reg <= sw_sync_reg[1];
    end
  end

  // index accepted once high for the filter length
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      idx_cnt_reg <= 24'h00_0000;
      idx_seen_reg <= 1'b0;
    end else if (!idx_sync_reg[1]) begin
      idx_cnt_reg <= 24'h00_0000;
      idx_seen_reg <= 1'b0;
    end else if (idx_cnt_reg < 24'(INDEX_FILTER - 1)) begin
      idx_cnt_reg <= idx_cnt_reg + 24'h00_0001;
      idx_seen_reg <= 1'b0;
    end else begin
      idx_seen_reg <= (idx_cnt_reg == 24'(INDEX_FILTER - 1));
      idx_cnt_reg <= INDEX_FILTER > 1 ? 24'(INDEX_FILTER) : 24'h00_0001;
    end
  end

  // ----------------------------------------
  // homing sequencer
  // ----------------------------------------
  homing_scale_pkg::home_state_t state_reg;
  logic sw_rise;
  assign sw_rise = sw_sync_reg[1] & ~sw_prev_reg;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= homing_scale_pkg::HOME_IDLE;
      speed_cmd <= 32'h0000_0000;
    end else begin
      case (state_reg)
        homing_scale_pkg::HOME_IDLE, homing_scale_pkg::HOME_DONE: begin
          if (home_start) begin
            state_reg <= homing_scale_pkg::HOME_RAMP;
            speed_cmd <= zero_speed_reg;
          end
        end
        homing_scale_pkg::HOME_RAMP: begin
          if (sw_rise) begin
            state_reg <= homing_scale_pkg::HOME_ZERO;
            speed_cmd <= zero_speed_reg;
          end else if (speed_tick) begin
            if (speed_cmd + ramp_accel_reg >= switch_speed_reg || speed_cmd + ramp_accel_reg < speed_cmd) begin
              speed_cmd <= switch_speed_reg;
              state_reg <= homing_scale_pkg::HOME_SWITCH;
            end else begin
              speed_cmd <= speed_cmd + ramp_accel_reg;
            end
          end
        end
        homing_scale_pkg::HOME_SWITCH: begin
          // switch seen, step down without ramp
          if (sw_rise) begin
            state_reg <= homing_scale_pkg::HOME_ZERO;
            speed_cmd <= zero_speed_reg;
          end
        end
        homing_scale_pkg::HOME_ZERO: begin
          if (idx_seen_reg) begin
            state_reg <= homing_scale_pkg::HOME_DONE;
            speed_cmd <= 32'h0000_0000;
          end
        end
        default: begin
          state_reg <= homing_scale_pkg::HOME_IDLE;
          speed_cmd <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign homing_busy = (state_reg != homing_scale_pkg::HOME_IDLE) && (state_reg != homing_scale_pkg::HOME_DONE);
  assign homing_done = (state_reg == homing_scale_pkg::HOME_DONE);
  assign speed_num = speed_num_reg;
  assign speed_den = speed_den_reg;
  assign accel_num = accel_num_reg;
  assign accel_den = accel_den_reg;
  assign jerk_num = jerk_num_reg;
  assign jerk_den = jerk_den_reg;
  assign gear_num = gear_motor_reg;
  assign gear_den = gear_shaft_reg;
  assign feed_num = feed_value_reg;
  assign feed_den = feed_shaft_reg;
  assign homing_method = method_reg;
  // jerk limit only for type 3 and non-zero magnitude
  assign jerk_limit_en = (ramp_type_reg == homing_scale_pkg::RAMP_JERK_LIMITED)
    && ((jerk_reg[0] | jerk_reg[1] | jerk_reg[2] | jerk_reg[3]) != 32'h0000_0000);
  assign jerk_accel_begin = jerk_limit_en ? jerk_reg[0] : 32'h0000_0000;
  assign jerk_brake_begin = jerk_limit_en ? jerk_reg[1] : 32'h0000_0000;
  assign jerk_accel_end = jerk_limit_en ? jerk_reg[2] : 32'h0000_0000;
  assign jerk_brake_end = jerk_limit_en ? jerk_reg[3] : 32'h0000_0000;
endmodule

// file: tb/homing_scale_asserts.sv
// Purpose: port-level checks of the homing and scaling block
// Assumes: one clock domain, mclk with arst_n
// Notes: a shadow of the reference speed entry is rebuilt from writes
`timescale 1ns/1ps
module homing_scale_asserts #(
  parameter int INDEX_FILTER = 4
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic od_wr,
  input wire logic od_rd,
  input wire logic [15:0] od_index,
  input wire logic [7:0] od_sub,
  input wire logic [31:0] od_wdata,
  input wire logic od_ack,
  input wire logic od_err,
  input wire logic home_start,
  input wire logic ref_switch,
  input wire logic [31:0] speed_cmd,
  input wire logic homing_busy,
  input wire logic homing_done,
  input wire logic [31:0] speed_den,
  input wire logic [31:0] accel_den,
  input wire logic [31:0] jerk_den,
  input wire logic [31:0] gear_den,
  input wire logic [31:0] feed_den,
  input wire logic jerk_limit_en,
  input wire logic [31:0] jerk_accel_begin
);
  logic [31:0] zero_spd_reg;
  // shadow of the reference search speed
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      zero_spd_reg <= homing_scale_pkg::ZERO_SPEED_RESET;
    end else if (od_wr && od_index == homing_scale_pkg::IDX_HOMING_SPEEDS && od_sub == 8'h02) begin
      zero_spd_reg <= od_wdata;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  chk_ack_follows_req: assert property ((od_wr || od_rd) |=> od_ack)
    else $error("no ack after request");
  chk_ack_needs_req: assert property (!(od_wr || od_rd) |=> !od_ack)
    else $error("ack without request");
  chk_den_never_zero: assert property (speed_den != 0 && accel_den != 0 && jerk_den != 0 && gear_den != 0 && feed_den != 0)
    else $error("zero denominator held");
  chk_zero_den_refused: assert property (od_wr && od_sub == 8'h02 && od_wdata == 0
    && od_index == homing_scale_pkg::IDX_SPEED_FACTOR |=> od_err && $stable(speed_den))
    else $error("zero denominator taken");
  chk_start_low_speed: assert property (home_start && !homing_busy |=> homing_busy && speed_cmd == zero_spd_reg)
    else $error("homing start speed wrong");
  chk_switch_speed_drop: assert property (homing_busy && $rose(ref_switch) |-> ##[1:6] speed_cmd == zero_spd_reg)
    else $error("no drop to reference speed");
  chk_done_stops: assert property ($rose(homing_done) |-> speed_cmd == 32'h0 && !homing_busy)
    else $error("motor not stopped at end");
  chk_jerk_gate_off: assert property (!jerk_limit_en |-> jerk_accel_begin == 32'h0)
    else $error("jerk value leaks while disabled");
endmodule
bind homing_scale homing_scale_asserts #(.INDEX_FILTER(INDEX_FILTER)) u_chk (.*);

// file: tb/motor_side_model.sv
// Purpose: motor side stand-in for reference switch and encoder index
// Assumes: requests come from the bench on mclk
// Notes: index mark lasts exactly the requested number of cycles
`timescale 1ns/1ps
module motor_side_model (
  input wire logic mclk,
  input wire logic sw_req,
  input wire logic ix_req,
  input wire logic [7:0] ix_width,
  output logic ref_switch,
  output logic index_pulse
);
  logic [7:0] ix_left_reg = 8'h00;
  // switch contact closes one cycle after the request
  always_ff @(posedge mclk) begin
    ref_switch <= sw_req;
  end
  always_ff @(posedge mclk) begin
    if (ix_req) begin
      ix_left_reg <= ix_width;
    end else if (ix_left_reg != 8'h00) begin
      ix_left_reg <= ix_left_reg - 8'h01;
    end
  end
  assign index_pulse = (ix_left_reg != 8'h00);
endmodule

// file: tb/test_homing_scale.sv
// Purpose: self-checking bench for the homing and scaling block
// Assumes: inputs change 1 ns after the rising edge
// Notes: index filter shortened to 4 cycles
`timescale 1ns/1ps
module test_homing_scale;
  localparam int FILT = 4;
  localparam logic [15:0] PAIRS [5] = '{16'h6091, 16'h6092, 16'h6096, 16'h6097, 16'h60a2};
  logic mclk, arst_n, od_wr, od_rd, od_ack, od_err, home_start, speed_tick, sw_req, ix_req;
  logic ref_switch, index_pulse, homing_busy, homing_done, jerk_limit_en;
  logic [15:0] od_index;
  logic [7:0] od_sub, ix_width, homing_method;
  logic [31:0] od_wdata, od_rdata, speed_cmd, j1, j2, j3, j4;
  logic [31:0] nums [5];
  logic [31:0] dens [5];
  int error_cnt, samples_checked, n;
  homing_scale #(.INDEX_FILTER(FILT)) dut (.mclk(mclk), .arst_n(arst_n), .od_wr(od_wr), .od_rd(od_rd),
    .od_index(od_index), .od_sub(od_sub), .od_wdata(od_wdata), .od_rdata(od_rdata), .od_ack(od_ack),
    .od_err(od_err), .home_start(home_start), .ref_switch(ref_switch), .index_pulse(index_pulse),
    .speed_tick(speed_tick), .speed_cmd(speed_cmd), .homing_busy(homing_busy), .homing_done(homing_done),
    .speed_num(nums[2]), .speed_den(dens[2]), .accel_num(nums[3]), .accel_den(dens[3]), .jerk_num(nums[4]),
    .jerk_den(dens[4]), .gear_num(nums[0]), .gear_den(dens[0]), .feed_num(nums[1]), .feed_den(dens[1]),
    .jerk_limit_en(jerk_limit_en), .jerk_accel_begin(j1), .jerk_accel_end(j3), .jerk_brake_begin(j2),
    .jerk_brake_end(j4), .homing_method(homing_method));
  motor_side_model partner (.mclk(mclk), .sw_req(sw_req), .ix_req(ix_req), .ix_width(ix_width),
    .ref_switch(ref_switch), .index_pulse(index_pulse));
  // -------------------------------
  // clock, compare and report
  // -------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task final_report;
    $display("compares %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one object access, answer sampled one cycle after the strobe
  task od_acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d,
    input logic [31:0] exp, input logic exp_err);
    @(posedge mclk);
    #1 {od_wr, od_rd, od_index, od_sub, od_wdata} = {wr, !wr, idx, sub, d};
    @(posedge mclk);
    #1 {od_wr, od_rd} = 2'b00;
    check({31'h0, od_ack}, 32'h1);
    check({31'h0, od_err}, {31'h0, exp_err});
    check(od_rdata, exp);
  endtask
  task wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d, input logic e);
    od_acc(1'b1, idx, sub, d, 32'h0, e);
  endtask
  task rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp);
    od_acc(1'b0, idx, sub, 32'h0, exp, 1'b0);
  endtask
  task pulse_tick(input logic [31:0] exp);
    @(posedge mclk);
    #1 speed_tick = 1'b1;
    @(posedge mclk);
    #1 speed_tick = 1'b0;
    check(speed_cmd, exp);
  endtask
  task pulse_start;
    @(posedge mclk);
    #1 home_start = 1'b1;
    @(posedge mclk);
    #1 home_start = 1'b0;
  endtask
  // -------------------------------
  // scenarios
  // -------------------------------
  task t_defaults;
    for (int i = 0; i < 5; i++) begin
      rd(PAIRS[i], 8'h00, 32'h2);
      rd(PAIRS[i], 8'h01, 32'h1);
      rd(PAIRS[i], 8'h02, 32'h1);
    end
    rd(16'h6099, 8'h01, 32'h32);
    rd(16'h6099, 8'h02, 32'h0a);
    rd(16'h609a, 8'h00, 32'h1f4);
    rd(16'h6098, 8'h00, 32'h23);
    check({24'h0, homing_method}, 32'h23);
    for (int j = 1; j < 5; j++) rd(16'h60a4, j[7:0], 32'h3e8);
    $display("t_defaults done");
  endtask
  task t_factors;
    for (int i = 0; i < 5; i++) begin
      wr(PAIRS[i], 8'h01, 32'h100 + i, 1'b0);
      wr(PAIRS[i], 8'h02, 32'h7 + i, 1'b0);
      wr(PAIRS[i], 8'h02, 32'h0, 1'b1);
      wr(PAIRS[i], 8'h00, 32'h5, 1'b1);
      rd(PAIRS[i], 8'h02, 32'h7 + i);
      check(nums[i], 32'h100 + i);
      check(dens[i], 32'h7 + i);
    end
    wr(16'h6000, 8'h01, 32'h1, 1'b1);
    $display("t_factors done");
  endtask
  task t_jerk;
    check({31'h0, jerk_limit_en}, 32'h0);
    wr(16'h6086, 8'h00, 32'h3, 1'b0);
    check({31'h0, jerk_limit_en}, 32'h1);
    check(j4, 32'h3e8);
    for (int j = 1; j < 5; j++) wr(16'h60a4, j[7:0], 32'h10 + j, 1'b0);
    check(j1, 32'h11);
    check(j2, 32'h12);
    check(j3, 32'h13);
    check(j4, 32'h14);
    for (int j = 1; j < 5; j++) wr(16'h60a4, j[7:0], 32'h0, 1'b0);
    check({31'h0, jerk_limit_en}, 32'h0);
    $display("t_jerk done");
  endtask
  task t_homing;
    wr(16'h6099, 8'h01, 32'h32, 1'b0);
    wr(16'h6099, 8'h02, 32'h0a, 1'b0);
    wr(16'h609a, 8'h00, 32'h10, 1'b0);
    pulse_start();
    check(speed_cmd, 32'h0a);
    check({31'h0, homing_busy}, 32'h1);
    pulse_tick(32'h1a);
    pulse_tick(32'h2a);
    pulse_tick(32'h32);
    pulse_start();
    check(speed_cmd, 32'h32);
    #0 sw_req = 1'b1;
    for (n = 0; n < 10 && speed_cmd !== 32'h0a; n++) @(posedge mclk);
    #1 check(speed_cmd, 32'h0a);
    pulse_tick(32'h0a);
    {ix_width, ix_req} = {FILT[7:0], 1'b1};
    @(posedge mclk);
    #1 ix_req = 1'b0;
    for (n = 0; n < 30 && homing_done !== 1'b1; n++) @(posedge mclk);
    #1 check({31'h0, homing_done}, 32'h1);
    check(speed_cmd, 32'h0);
    sw_req = 1'b0;
    $display("t_homing done");
  endtask
  task t_reset;
    @(posedge mclk);
    #1 arst_n = 1'b0;
    @(posedge mclk);
    #1 arst_n = 1'b1;
    check({31'h0, homing_done}, 32'h0);
    check(speed_cmd, 32'h0);
    rd(16'h6091, 8'h01, 32'h1);
    rd(16'h6099, 8'h02, 32'h0a);
    rd(16'h60a4, 8'h02, 32'h3e8);
    $display("t_reset done");
  endtask
  initial begin
    {arst_n, od_wr, od_rd, home_start, speed_tick, sw_req, ix_req} = 7'h0;
    {od_index, od_sub, od_wdata, ix_width} = 64'h0;
    repeat (4) @(posedge mclk);
    #1 arst_n = 1'b1;
    t_defaults();
    t_factors();
    t_jerk();
    t_homing();
    t_reset();
    final_report();
  end
  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    final_report();
  end
endmodule
